// ===== rtl/tmr_pkg.sv
// constants for the two channel modulo timer
// Overview of operation
// - select code 111 clocks from external pin
// - codes 000-110 divide bus clock 1..64
// - external pin forced input while selected
// - each channel capture or compare independently when unbuffered
// - overflow flag on wrap; reset clears, one ignored
// - clear flag by read then zero write
// - overflow interrupt when flag and enable set
// - halt bit holds counter; set by reset
// - halt inhibits input captures
// - clear bit resets counter and prescaler, reads zero
// - halt plus clear stops counter at zero
// - high byte read latches low byte
// - counter equal modulo sets flag, restarts zero
// - modulo high write inhibits flag until low
// - reset sets all modulo bits
// - channel flag on edge or compare match
// - channel flag read-then-zero clear, one ignored
// - channel interrupt when flag and enable set
// - buffered bit on channel 0 disables channel 1
// - edge select picks capture edge or compare action
// - overflow toggle wins over coincident compare
// - buffered mode swaps to last written pair
// - value high byte access inhibits until low byte
package tmr_pkg;
  // ****************
  // register indices
  // ****************
  localparam logic [7:0] IDX_CTRL = 8'h40;
  localparam logic [7:0] IDX_CNTH = 8'h41;
  localparam logic [7:0] IDX_CNTL = 8'h42;
  localparam logic [7:0] IDX_MODH = 8'h43;
  localparam logic [7:0] IDX_MODL = 8'h44;
  localparam logic [7:0] IDX_SC0  = 8'h45;
  localparam logic [7:0] IDX_V0H  = 8'h46;
  localparam logic [7:0] IDX_V0L  = 8'h47;
  localparam logic [7:0] IDX_SC1  = 8'h48;
  localparam logic [7:0] IDX_V1H  = 8'h49;
  localparam logic [7:0] IDX_V1L  = 8'h4a;
  // ****************
  // field positions
  // ****************
  localparam int C_OVF  = 7;
  localparam int C_OIE  = 6;
  localparam int C_HALT = 5;
  localparam int C_CLR  = 4;
  localparam int H_FLG  = 7;
  localparam int H_IE   = 6;
  localparam int H_MSB  = 5;
  localparam int H_MSA  = 4;
  localparam int H_ELS  = 2;
  localparam int H_TOV  = 1;
  localparam int H_MAX  = 0;
  // ****************
  // codes and reset values
  // ****************
  localparam logic [2:0]  SEL_EXT  = 3'h7;
  localparam logic [1:0]  ELS_OFF  = 2'h0;
  localparam logic [1:0]  ELS_RISE = 2'h1;
  localparam logic [1:0]  ELS_FALL = 2'h2;
  localparam logic [1:0]  ELS_BOTH = 2'h3;
  localparam logic [7:0]  CTRL_RST = 8'h20;
  localparam logic [15:0] MOD_RST  = 16'hffff;
  localparam logic [1:0]  RESP_OK  = 2'h0;
  localparam logic [1:0]  RESP_ERR = 2'h2;
endpackage : tmr_pkg

// ===== rtl/tmr_two_channel_modulo_timer.sv
// two channel modulo timer with axi4-lite registers
module tmr_two_channel_modulo_timer #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // axi4-lite write
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // external clock pin
  input  wire logic              extClkPin,
  input  wire logic              portDDirBit,
  output logic                   extClkPinOe,
  // channel pins
  input  wire logic [1:0]        chPinIn,
  output logic [1:0]             chPinOut,
  output logic [1:0]             chPinOe,
  // interrupt requests
  output logic                   ovfIrq,
  output logic [1:0]             chIrq
);
  if (ADDR_W < 11) begin : g_chk
    $error("ADDR_W too small for register map");
  end

  // ****************
  // bus slave
  // ****************
  logic              awHeld_ff, wHeld_ff, bvalid_ff, rvalid_ff, wLane_ff;
  logic [ADDR_W-1:0] awAddr_ff;
  logic [7:0]        wData_ff, rdata_ff, rdMux;
  logic [1:0]        bresp_ff, rresp_ff;
  logic              doWr, doRd, wHit, rHit, rMapped, wMapped;
  logic [7:0]        wIdx, rIdx;

  assign awready = !awHeld_ff && !bvalid_ff;
  assign wready  = !wHeld_ff && !bvalid_ff;
  assign arready = !rvalid_ff;
  assign doWr    = awHeld_ff && wHeld_ff && !bvalid_ff;
  assign doRd    = arvalid && arready;
  assign wIdx    = awAddr_ff[9:2];
  assign rIdx    = araddr[9:2];
  assign wHit    = (awAddr_ff[ADDR_W-1:10] == '0) && (awAddr_ff[1:0] == 2'h0);
  assign rHit    = (araddr[ADDR_W-1:10] == '0) && (araddr[1:0] == 2'h0);
  assign wMapped = wHit && (wIdx >= tmr_pkg::IDX_CTRL) && (wIdx <= tmr_pkg::IDX_V1L);
  assign rMapped = rHit && (rIdx >= tmr_pkg::IDX_CTRL) && (rIdx <= tmr_pkg::IDX_V1L);
  assign bvalid  = bvalid_ff;
  assign bresp   = bresp_ff;
  assign rvalid  = rvalid_ff;
  assign rresp   = rresp_ff;
  assign rdata   = {24'h000000, rdata_ff};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awHeld_ff <= 1'b0;
      wHeld_ff  <= 1'b0;
      bvalid_ff <= 1'b0;
      awAddr_ff <= '0;
      wData_ff  <= 8'h00;
      wLane_ff  <= 1'b0;
      bresp_ff  <= tmr_pkg::RESP_OK;
    end else begin
      if (awvalid && awready) begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld_ff <= 1'b1;
        wData_ff <= wdata[7:0];
        wLane_ff <= wstrb[0];
      end
      if (doWr) begin
        awHeld_ff <= 1'b0;
        wHeld_ff  <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff  <= wMapped ? tmr_pkg::RESP_OK : tmr_pkg::RESP_ERR;
      end else if (bvalid_ff && bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 8'h00;
      rresp_ff  <= tmr_pkg::RESP_OK;
    end else if (doRd) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rMapped ? rdMux : 8'h00;
      rresp_ff  <= rMapped ? tmr_pkg::RESP_OK : tmr_pkg::RESP_ERR;
    end else if (rvalid_ff && rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // per-register strobes
  logic wrEn, rdEn;
  assign wrEn = doWr && wMapped && wLane_ff;
  assign rdEn = doRd && rMapped;
  logic wrCtrl, wrModH, wrModL, rdCtrl, rdCntH, rdCntL;
  assign wrCtrl = wrEn && (wIdx == tmr_pkg::IDX_CTRL);
  assign wrModH = wrEn && (wIdx == tmr_pkg::IDX_MODH);
  assign wrModL = wrEn && (wIdx == tmr_pkg::IDX_MODL);
  assign rdCtrl = rdEn && (rIdx == tmr_pkg::IDX_CTRL);
  assign rdCntH = rdEn && (rIdx == tmr_pkg::IDX_CNTH);
  assign rdCntL = rdEn && (rIdx == tmr_pkg::IDX_CNTL);

  // ****************
  // clock source and counter
  // ****************
  logic        ovf_ff, oie_ff, halt_ff, ovfArm_ff, modInh_ff, cntLat_ff;
  logic [2:0]  sel_ff;
  logic [5:0]  pre_ff, preMask;
  logic [15:0] cnt_ff, mod_ff, nxtCnt;
  logic [7:0]  cntLow_ff;
  logic        ext1_ff, ext2_ff, ext3_ff;
  logic        extSel, srcTick, cntTick, wrap, cntOvf, ovfEvt, clrCmd;

  assign extSel      = (sel_ff == tmr_pkg::SEL_EXT);
  assign extClkPinOe = portDDirBit && !extSel;
  assign preMask     = ~(6'h3f << sel_ff);
  assign srcTick     = extSel ? (ext2_ff && !ext3_ff)
                              : (&(pre_ff | ~preMask));
  assign cntTick     = !halt_ff && srcTick;
  assign wrap        = (cnt_ff == mod_ff);
  assign nxtCnt      = wrap ? 16'h0000 : cnt_ff + 16'h0001;
  assign cntOvf      = cntTick && wrap;
  assign ovfEvt      = cntOvf && !modInh_ff;
  assign clrCmd      = wrCtrl && wData_ff[tmr_pkg::C_CLR];
  assign ovfIrq      = ovf_ff && oie_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext1_ff <= 1'b0;
      ext2_ff <= 1'b0;
      ext3_ff <= 1'b0;
    end else begin
      ext1_ff <= extClkPin;
      ext2_ff <= ext1_ff;
      ext3_ff <= ext2_ff;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_ff <= 6'h00;
      cnt_ff <= 16'h0000;
    end else if (clrCmd) begin
      pre_ff <= 6'h00;
      cnt_ff <= 16'h0000;
    end else if (!halt_ff) begin
      pre_ff <= pre_ff + 6'h01;
      if (cntTick) begin
        cnt_ff <= nxtCnt;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ovf_ff    <= tmr_pkg::CTRL_RST[tmr_pkg::C_OVF];
      oie_ff    <= tmr_pkg::CTRL_RST[tmr_pkg::C_OIE];
      halt_ff   <= tmr_pkg::CTRL_RST[tmr_pkg::C_HALT];
      sel_ff    <= tmr_pkg::CTRL_RST[2:0];
      ovfArm_ff <= 1'b0;
    end else begin
      if (wrCtrl) begin
        oie_ff  <= wData_ff[tmr_pkg::C_OIE];
        halt_ff <= wData_ff[tmr_pkg::C_HALT];
        sel_ff  <= wData_ff[2:0];
      end
      if (ovfEvt) begin
        ovf_ff    <= 1'b1;
        ovfArm_ff <= 1'b0;
      end else if (wrCtrl && !wData_ff[tmr_pkg::C_OVF] && ovfArm_ff) begin
        ovf_ff    <= 1'b0;
        ovfArm_ff <= 1'b0;
      end else if (rdCtrl && ovf_ff) begin
        ovfArm_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mod_ff    <= tmr_pkg::MOD_RST;
      modInh_ff <= 1'b0;
      cntLat_ff <= 1'b0;
      cntLow_ff <= 8'h00;
    end else begin
      if (wrModH) begin
        mod_ff[15:8] <= wData_ff;
        modInh_ff    <= 1'b1;
      end
      if (wrModL) begin
        mod_ff[7:0] <= wData_ff;
        modInh_ff   <= 1'b0;
      end
      if (rdCntL) begin
        cntLat_ff <= 1'b0;
      end else if (rdCntH && !cntLat_ff) begin
        cntLat_ff <= 1'b1;
        cntLow_ff <= cnt_ff[7:0];
      end
    end
  end

  // ****************
  // channels
  // ****************
  logic        bufMode_ff, lastWr_ff, actSel_ff;
  logic [15:0] val [2];
  logic [7:0]  scRd [2];
  logic [7:0]  hiRd [2];
  logic [7:0]  loRd [2];
  logic [1:0]  loWr;

  for (genvar i = 0; i < 2; i++) begin : g_ch
    localparam logic [7:0] SCI = (i == 0) ? tmr_pkg::IDX_SC0 : tmr_pkg::IDX_SC1;
    localparam logic [7:0] VHI = (i == 0) ? tmr_pkg::IDX_V0H : tmr_pkg::IDX_V1H;
    localparam logic [7:0] VLI = (i == 0) ? tmr_pkg::IDX_V0L : tmr_pkg::IDX_V1L;
    logic        flg_ff, ie_ff, msa_ff, tov_ff, max_ff, arm_ff, capInh_ff, cmpInh_ff, out_ff;
    logic [1:0]  els_ff;
    logic [15:0] val_ff, cmpVal;
    logic        p1_ff, p2_ff, p3_ff;
    logic        chEn, msb, isCap, isCmp, edgeHit, capEvt, cmpEvt, evt;
    logic        wrSc, wrHi, wrLo, rdSc, rdHi, rdLo;

    assign msb     = (i == 0) ? bufMode_ff : 1'b0;
    assign chEn    = (i == 0) || !bufMode_ff;
    assign isCap   = chEn && !msb && !msa_ff && (els_ff != tmr_pkg::ELS_OFF);
    assign isCmp   = chEn && (msb || msa_ff) && (els_ff != tmr_pkg::ELS_OFF);
    assign edgeHit = ((els_ff == tmr_pkg::ELS_RISE) && p2_ff && !p3_ff) ||
                     ((els_ff == tmr_pkg::ELS_FALL) && !p2_ff && p3_ff) ||
                     ((els_ff == tmr_pkg::ELS_BOTH) && (p2_ff != p3_ff));
    assign capEvt  = isCap && edgeHit && !halt_ff && !capInh_ff;
    assign cmpVal  = (msb && actSel_ff) ? val[1] : val_ff;
    assign cmpEvt  = isCmp && cntTick && (nxtCnt == cmpVal) && !cmpInh_ff;
    assign evt     = capEvt || cmpEvt;
    assign wrSc    = wrEn && (wIdx == SCI) && chEn;
    assign wrHi    = wrEn && (wIdx == VHI);
    assign wrLo    = wrEn && (wIdx == VLI);
    assign rdSc    = rdEn && (rIdx == SCI) && chEn;
    assign rdHi    = rdEn && (rIdx == VHI);
    assign rdLo    = rdEn && (rIdx == VLI);
    assign val[i]  = val_ff;
    assign loWr[i] = wrLo;
    assign hiRd[i] = val_ff[15:8];
    assign loRd[i] = val_ff[7:0];
    assign scRd[i] = chEn ? {flg_ff, ie_ff, msb, msa_ff, els_ff, tov_ff, max_ff} : 8'h00;
    assign chIrq[i]    = flg_ff && ie_ff;
    assign chPinOe[i]  = isCmp && ((i == 0) || !bufMode_ff);
    assign chPinOut[i] = out_ff;

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        p1_ff <= 1'b0;
        p2_ff <= 1'b0;
        p3_ff <= 1'b0;
      end else begin
        p1_ff <= chPinIn[i];
        p2_ff <= p1_ff;
        p3_ff <= p2_ff;
      end
    end

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        flg_ff <= 1'b0;
        ie_ff  <= 1'b0;
        msa_ff <= 1'b0;
        els_ff <= tmr_pkg::ELS_OFF;
        tov_ff <= 1'b0;
        max_ff <= 1'b0;
        arm_ff <= 1'b0;
      end else begin
        if (wrSc) begin
          ie_ff  <= wData_ff[tmr_pkg::H_IE];
          msa_ff <= wData_ff[tmr_pkg::H_MSA];
          els_ff <= wData_ff[tmr_pkg::H_ELS+:2];
          tov_ff <= wData_ff[tmr_pkg::H_TOV];
          max_ff <= wData_ff[tmr_pkg::H_MAX];
        end
        if (evt) begin
          flg_ff <= 1'b1;
          arm_ff <= 1'b0;
        end else if (wrSc && !wData_ff[tmr_pkg::H_FLG] && arm_ff) begin
          flg_ff <= 1'b0;
          arm_ff <= 1'b0;
        end else if (rdSc && flg_ff) begin
          arm_ff <= 1'b1;
        end
      end
    end

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        val_ff    <= 16'h0000;
        capInh_ff <= 1'b0;
        cmpInh_ff <= 1'b0;
      end else begin
        if (capEvt) begin
          val_ff <= cnt_ff;
        end else if (wrHi) begin
          val_ff[15:8] <= wData_ff;
        end else if (wrLo) begin
          val_ff[7:0] <= wData_ff;
        end
        if (wrHi && (msb || msa_ff)) begin
          cmpInh_ff <= 1'b1;
        end else if (wrLo) begin
          cmpInh_ff <= 1'b0;
        end
        if (rdLo) begin
          capInh_ff <= 1'b0;
        end else if (rdHi && !msb && !msa_ff) begin
          capInh_ff <= 1'b1;
        end
      end
    end

    // output level: overflow first, then compare
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        out_ff <= 1'b1;
      end else if (els_ff == tmr_pkg::ELS_OFF) begin
        out_ff <= !msa_ff;
      end else if (isCmp && cntOvf && tov_ff) begin
        out_ff <= !out_ff;
      end else if (isCmp && cntOvf && max_ff) begin
        out_ff <= 1'b1;
      end else if (cmpEvt && !max_ff) begin
        case (els_ff)
          tmr_pkg::ELS_RISE: out_ff <= !out_ff;
          tmr_pkg::ELS_FALL: out_ff <= 1'b0;
          default:           out_ff <= 1'b1;
        endcase
      end
    end
  end

  // buffered pair selection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bufMode_ff <= 1'b0;
      lastWr_ff  <= 1'b0;
      actSel_ff  <= 1'b0;
    end else begin
      if (g_ch[0].wrSc) begin
        bufMode_ff <= wData_ff[tmr_pkg::H_MSB];
      end
      if (loWr[1]) begin
        lastWr_ff <= 1'b1;
      end else if (loWr[0]) begin
        lastWr_ff <= 1'b0;
      end
      if (!bufMode_ff) begin
        actSel_ff <= 1'b0;
      end else if (cntOvf) begin
        actSel_ff <= lastWr_ff;
      end
    end
  end

  // ****************
  // read data select
  // ****************
  always_comb begin
    case (rIdx)
      tmr_pkg::IDX_CTRL: rdMux = {ovf_ff, oie_ff, halt_ff, 1'b0, 1'b0, sel_ff};
      tmr_pkg::IDX_CNTH: rdMux = cnt_ff[15:8];
      tmr_pkg::IDX_CNTL: rdMux = cntLat_ff ? cntLow_ff : cnt_ff[7:0];
      tmr_pkg::IDX_MODH: rdMux = mod_ff[15:8];
      tmr_pkg::IDX_MODL: rdMux = mod_ff[7:0];
      tmr_pkg::IDX_SC0:  rdMux = scRd[0];
      tmr_pkg::IDX_V0H:  rdMux = hiRd[0];
      tmr_pkg::IDX_V0L:  rdMux = loRd[0];
      tmr_pkg::IDX_SC1:  rdMux = scRd[1];
      tmr_pkg::IDX_V1H:  rdMux = hiRd[1];
      tmr_pkg::IDX_V1L:  rdMux = loRd[1];
      default:           rdMux = 8'h00;
    endcase
  end
endmodule : tmr_two_channel_modulo_timer

// ===== bench/tmr_timer_assertions.sv
// port level assertions for the modulo timer
module tmr_timer_assertions #(
  parameter int ADDR_W = 12
) (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              awvalid,
  input wire logic              awready,
  input wire logic              wvalid,
  input wire logic              wready,
  input wire logic [1:0]        bresp,
  input wire logic              bvalid,
  input wire logic              bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic              arvalid,
  input wire logic              arready,
  input wire logic [31:0]       rdata,
  input wire logic [1:0]        rresp,
  input wire logic              rvalid,
  input wire logic              rready,
  input wire logic              portDDirBit,
  input wire logic              extClkPinOe,
  input wire logic              ovfIrq,
  input wire logic [1:0]        chIrq
);
  default clocking @(posedge clk); endclocking
  default disable iff rst;
  property p_wr_resp;
    awvalid && awready && wvalid && wready |=> !awready ##1 bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write response late");
  property p_b_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_b_block;
    bvalid |-> !awready && !wready;
  endproperty
  a_b_block: assert property (p_b_block) else $error("write accepted while busy");
  property p_r_lat;
    arvalid && arready |=> rvalid;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("read data late");
  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_r_upper;
    rvalid |-> rdata[31:8] == 24'h0 && !arready;
  endproperty
  a_r_upper: assert property (p_r_upper) else $error("read upper bits or ready");
  property p_r_unmap;
    arvalid && arready && (araddr[9:2] < 8'h40 || araddr[9:2] > 8'h4a)
      |=> rresp == tmr_pkg::RESP_ERR && rdata == 32'h0;
  endproperty
  a_r_unmap: assert property (p_r_unmap) else $error("unmapped read not refused");
  property p_pin_in;
    !portDDirBit |-> !extClkPinOe;
  endproperty
  a_pin_in: assert property (p_pin_in) else $error("clock pin driven");
  property p_irq_rst;
    $fell(rst) |-> !ovfIrq && chIrq == 2'h0;
  endproperty
  a_irq_rst: assert property (p_irq_rst) else $error("irq after reset");
endmodule : tmr_timer_assertions

// ===== bench/tb_tmr_two_channel_modulo_timer.sv
// self-checking bench for the modulo timer
module tb_tmr_two_channel_modulo_timer;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CTL = tmr_pkg::IDX_CTRL;
  localparam logic [7:0] CNH = tmr_pkg::IDX_CNTH;
  localparam logic [7:0] CNL = tmr_pkg::IDX_CNTL;
  localparam logic [7:0] MDH = tmr_pkg::IDX_MODH;
  localparam logic [7:0] MDL = tmr_pkg::IDX_MODL;
  localparam logic [7:0] SC0 = tmr_pkg::IDX_SC0;
  localparam logic [7:0] SC1 = tmr_pkg::IDX_SC1;
  logic        clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, extClkPin, portDDirBit;
  logic        extClkPinOe, ovfIrq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, lastResp, chPinIn, chPinOut, chPinOe, chIrq;
  logic [7:0]  h, l;
  int          errTotal, compares;
  tmr_two_channel_modulo_timer dut (
    .clk(clk), .rst(rst),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .extClkPin(extClkPin), .portDDirBit(portDDirBit), .extClkPinOe(extClkPinOe),
    .chPinIn(chPinIn), .chPinOut(chPinOut), .chPinOe(chPinOe),
    .ovfIrq(ovfIrq), .chIrq(chIrq)
  );
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    compares++;
    if (s !== e) begin
      errTotal++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic ta, tw, tb;
    awaddr  <= {2'h0, idx, 2'h0};
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
  endtask : wr
  task automatic rd(input logic [7:0] idx, output logic [7:0] d);
    logic ta, tr;
    araddr  <= {2'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge clk);
      ta = arvalid && arready;
      tr = rvalid;
      d = rdata[7:0];
      lastResp = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
    end
  endtask : rd
  task automatic rc(input logic [7:0] idx, input string nm, input logic [7:0] e);
    logic [7:0] v;
    rd(idx, v);
    chk(nm, e, v);
  endtask : rc
  // exact counter ticks on the external clock pin
  task automatic pulses(input int n);
    repeat (n) begin
      extClkPin <= 1'b1;
      repeat (4) @(posedge clk);
      extClkPin <= 1'b0;
      repeat (4) @(posedge clk);
    end
    repeat (6) @(posedge clk);
  endtask : pulses
  task automatic print_verdict;
    $display("compares %0d errors %0d", compares, errTotal);
    if (errTotal == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict
  // ****************
  // scenarios
  // ****************
  task automatic t_reset;
    rc(CTL, "ctrl", tmr_pkg::CTRL_RST);
    wstrb <= 4'he;
    wr(MDH, 8'h00);
    wstrb <= 4'hf;
    rc(MDH, "modh", 8'hff);
    rc(MDL, "modl", 8'hff);
    rc(CNL, "cntl", 8'h00);
    rc(SC0, "sc0", 8'h00);
    rc(8'h3f, "unmapped", 8'h00);
    chk("resp", {6'h0, tmr_pkg::RESP_ERR}, {6'h0, lastResp});
    $display("reset test done");
  endtask : t_reset
  task automatic t_presc;
    for (int s = 0; s < 7; s++) begin
      wr(CTL, 8'h30 | 8'(s));
      wr(CTL, 8'(s));
      repeat (128) @(posedge clk);
      wr(CTL, 8'h20 | 8'(s));
      rd(CNH, h);
      rd(CNL, l);
      chk("divide", 8'h1, {7'h0, h == 0 && l >= (128 >> s) && l <= (140 >> s) + 1});
    end
    $display("prescaler test done");
  endtask : t_presc
  task automatic t_ext;
    portDDirBit <= 1'b1;
    wr(CTL, 8'h37);
    chk("pin oe", 8'h0, {7'h0, extClkPinOe});
    wr(CTL, 8'h07);
    pulses(5);
    wr(CTL, 8'h27);
    rd(CNH, h);
    rc(CNL, "ext count", 8'h05);
    wr(CTL, 8'h20);
    chk("pin oe", 8'h1, {7'h0, extClkPinOe});
    $display("external clock test done");
  endtask : t_ext
  task automatic t_latch;
    wr(CTL, 8'h30);
    rd(CNH, h);
    wr(CTL, 8'h00);
    repeat (50) @(posedge clk);
    rd(CNH, h);
    wr(CTL, 8'h20);
    rc(CNL, "latched", 8'h00);
    rd(CNH, h);
    rd(CNL, l);
    chk("relatch", 8'h1, {7'h0, l > 8'd50});
    $display("latch test done");
  endtask : t_latch
  task automatic t_ovf;
    wr(CTL, 8'h30);
    wr(MDH, 8'h00);
    wr(MDL, 8'h09);
    wr(CTL, 8'h40);
    repeat (30) @(posedge clk);
    chk("ovf irq", 8'h1, {7'h0, ovfIrq});
    rd(CTL, h);
    repeat (12) @(posedge clk);
    wr(CTL, 8'h60);
    rc(CTL, "kept", 8'he0);
    wr(CTL, 8'h60);
    rc(CTL, "cleared", 8'h60);
    chk("irq off", 8'h0, {7'h0, ovfIrq});
    wr(CTL, 8'he0);
    rc(CTL, "one ignored", 8'h60);
    wr(CTL, 8'h30);
    wr(MDH, 8'h00);
    wr(CTL, 8'h00);
    repeat (40) @(posedge clk);
    wr(CTL, 8'h20);
    rc(CTL, "inhibit", 8'h20);
    wr(MDL, 8'h09);
    wr(CTL, 8'h10);
    repeat (40) @(posedge clk);
    wr(CTL, 8'h20);
    rc(CTL, "wrap flag", 8'ha0);
    rd(CNH, h);
    rd(CNL, l);
    chk("wrap", 8'h1, {7'h0, h == 0 && l <= 8'h09});
    $display("overflow test done");
  endtask : t_ovf
  task automatic t_chan;
    wr(CTL, 8'h30);
    wr(SC0, 8'h44);
    chPinIn <= 2'h1;
    repeat (6) @(posedge clk);
    rc(SC0, "halt capture", 8'h44);
    chPinIn <= 2'h0;
    wr(CTL, 8'h00);
    chPinIn <= 2'h1;
    repeat (6) @(posedge clk);
    chk("ch irq", 8'h1, {7'h0, chIrq[0]});
    rc(SC0, "cap flag", 8'hc4);
    wr(SC0, 8'h44);
    rc(SC0, "cap clear", 8'h44);
    wr(CTL, 8'h30);
    wr(tmr_pkg::IDX_V1H, 8'h00);
    wr(tmr_pkg::IDX_V1L, 8'h05);
    wr(SC1, 8'h18);
    chk("oe", 8'h2, {6'h0, chPinOe});
    wr(CTL, 8'h10);
    repeat (30) @(posedge clk);
    chk("cmp out", 8'h0, {7'h0, chPinOut[1]});
    rc(SC1, "cmp flag", 8'h98);
    wr(SC0, 8'h28);
    chk("oe buf", 8'h0, {7'h0, chPinOe[1]});
    rc(SC1, "sc1 off", 8'h00);
    $display("channel test done");
  endtask : t_chan
  task automatic t_cmp;
    wr(CTL, 8'h37);
    rd(SC0, h);
    wr(SC0, 8'h00);
    wr(tmr_pkg::IDX_V0H, 8'h00);
    wr(tmr_pkg::IDX_V0L, 8'h00);
    wr(SC0, 8'h1e);
    wr(CTL, 8'h07);
    pulses(10);
    chk("ovf wins", 8'h0, {7'h0, chPinOut[0]});
    rc(SC0, "cmp at ovf", 8'h9e);
    wr(SC0, 8'h1e);
    wr(tmr_pkg::IDX_V0H, 8'h00);
    pulses(10);
    chk("ovf toggle", 8'h1, {7'h0, chPinOut[0]});
    rc(SC0, "cmp inhibit", 8'h1e);
    wr(tmr_pkg::IDX_V0L, 8'h00);
    pulses(10);
    rc(SC0, "cmp resume", 8'h9e);
    wr(SC0, 8'h2c);
    wr(tmr_pkg::IDX_V1H, 8'h00);
    wr(tmr_pkg::IDX_V1L, 8'h03);
    pulses(10);
    rd(SC0, h);
    wr(SC0, 8'h2c);
    pulses(3);
    rc(SC0, "buffered", 8'hac);
    $display("compare test done");
  endtask : t_cmp
  initial begin
    rst <= 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, extClkPin, portDDirBit} <= '0;
    {awaddr, araddr, wdata, chPinIn} <= '0;
    wstrb <= 4'hf;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_presc();
    t_ext();
    t_latch();
    t_ovf();
    t_chan();
    t_cmp();
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk);
    errTotal++;
    print_verdict();
  end
endmodule : tb_tmr_two_channel_modulo_timer
bind tmr_two_channel_modulo_timer tmr_timer_assertions #(.ADDR_W(ADDR_W)) u_chk (
  .clk(clk), .rst(rst), .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
  .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
  .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
  .portDDirBit(portDDirBit), .extClkPinOe(extClkPinOe), .ovfIrq(ovfIrq), .chIrq(chIrq)
);
